// *** hw/amc_core.sv ***
// alu, multiplier, divider and cpu control bits of the core
// Function
// - sixteen-bit add, subtract, shift and logic
// - arithmetic uses two's complement numbers
// - update carry, zero, negative, wrap, nibble flags
// - subtraction carry and nibble mean not-borrow
// - byte or word width per instruction
// - operands and results: register array or memory
// - hardware multiplier and sixteen-bit divisor division
// - multiplier is seventeen by seventeen array
// - signed, unsigned, mixed, literal and byte modes
// - control bit 3 shows priority above seven
// - that bit set blocks user interrupts
// - control bit 2 maps program into data
// - other control bits read as zero
`timescale 1ns/1ps
module amc_core
	import amc_pkg::*;
(
	input wire logic sys_clk,
	input wire logic rst_n,
	input wire logic req_valid,
	input wire amc_req_t req,
	input wire logic [3:0] cpu_priority,
	input wire logic user_irq_req,
	input wire logic [3:0] reg_addr,
	input wire logic [15:0] reg_wdata,
	input wire logic reg_wr,
	input wire logic reg_rd,
	output logic [15:0] reg_rdata,
	output logic rsp_valid,
	output amc_rsp_t rsp,
	output logic busy,
	output logic wreg_we,
	output logic dmem_we,
	output logic user_irq_take,
	output logic program_space_window_enable
);

	typedef enum logic [1:0] {
		AMC_ST_IDLE,
		AMC_ST_DIV,
		AMC_ST_DIV_DONE
	} amc_state_t;

	amc_state_t state_q;
	logic [15:0] alu_flag_word_q;
	logic priority_above_seven_status_q;
	logic [15:0] res_lo_q;
	logic [15:0] res_hi_q;
	logic [15:0] rem_q;
	logic [15:0] rdata_q;
	logic rsp_valid_q;
	amc_rsp_t rsp_q;
	logic wreg_we_q;
	logic dmem_we_q;
	logic irq_take_q;
	logic window_q;
	logic busy_q;
	logic [31:0] mul_product;
	logic [15:0] alu_res;
	logic [15:0] flags_d;
	logic alu_carry;
	logic alu_nibble;
	logic alu_wrap;
	logic [16:0] sum17;
	logic [4:0] nib5;
	logic [15:0] b_eff;
	logic cin;
	logic is_sub;
	logic msb_res;
	logic [15:0] div_rem_q;
	logic [15:0] div_quo_q;
	logic [15:0] div_den_q;
	logic [4:0] div_cnt_q;
	logic div_neg_q;
	logic div_rneg_q;
	amc_src_t div_dst_q;
	logic [16:0] div_trial;
	logic [15:0] div_shift;
	logic [15:0] ctl_view;

	// one shared 17x17 array serves every multiply mode
	amc_mul17 u_mul (
		.opa(req.opa),
		.opb(req.opb),
		.mode(req.mul_mode),
		.product(mul_product)
	);

	// adder, logic and shifter; subtract is add of inverted b plus one
	always_comb
	begin
		is_sub = (req.op == AMC_OP_SUB) || (req.op == AMC_OP_SUBB);
		b_eff = is_sub ? ~req.opb : req.opb;
		case (req.op)
			AMC_OP_SUB: cin = 1'b1;
			AMC_OP_ADDC, AMC_OP_SUBB: cin = alu_flag_word_q[AMC_FLG_CARRY];
			default: cin = 1'b0;
		endcase
		sum17 = {1'b0, req.opa} + {1'b0, b_eff} + {16'h0000, cin};
		nib5 = {1'b0, req.opa[3:0]} + {1'b0, b_eff[3:0]} + {4'h0, cin};
		alu_res = sum17[15:0];
		alu_carry = req.byte_mode ? (req.opa[8] ^ b_eff[8] ^ sum17[8]) : sum17[16];
		alu_nibble = nib5[4]; // inverted b makes this a not-borrow
		alu_wrap = 1'b0;
		case (req.op)
			AMC_OP_AND: alu_res = req.opa & req.opb;
			AMC_OP_OR: alu_res = req.opa | req.opb;
			AMC_OP_XOR: alu_res = req.opa ^ req.opb;
			AMC_OP_SHL:
			begin
				alu_res = {req.opa[14:0], 1'b0};
				alu_carry = req.byte_mode ? req.opa[7] : req.opa[15];
			end
			AMC_OP_SHR:
			begin
				alu_res = req.byte_mode ? {8'h00, 1'b0, req.opa[7:1]} : {1'b0, req.opa[15:1]};
				alu_carry = req.opa[0];
			end
			AMC_OP_ASR:
			begin
				alu_res = req.byte_mode ? {8'h00, req.opa[7], req.opa[7:1]} : {req.opa[15], req.opa[15:1]};
				alu_carry = req.opa[0];
			end
			default:
			begin
				// signed wrap when operand signs agree and result differs
				if (req.byte_mode)
					alu_wrap = (req.opa[7] == b_eff[7]) && (sum17[7] != req.opa[7]);
				else
					alu_wrap = (req.opa[15] == b_eff[15]) && (sum17[15] != req.opa[15]);
			end
		endcase
		if (req.byte_mode)
			alu_res = {8'h00, alu_res[7:0]};
		msb_res = req.byte_mode ? alu_res[7] : alu_res[15];
	end

	// flag update per operation class; logic ops keep carry and wrap
	always_comb
	begin
		flags_d = alu_flag_word_q;
		flags_d[AMC_FLG_ZERO] = req.byte_mode ? (alu_res[7:0] == 8'h00) : (alu_res == 16'h0000);
		flags_d[AMC_FLG_NEG] = msb_res;
		case (req.op)
			AMC_OP_ADD, AMC_OP_ADDC, AMC_OP_SUB, AMC_OP_SUBB:
			begin
				flags_d[AMC_FLG_CARRY] = alu_carry;
				flags_d[AMC_FLG_NIBBLE] = alu_nibble;
				flags_d[AMC_FLG_WRAP] = alu_wrap;
			end
			AMC_OP_SHL, AMC_OP_SHR, AMC_OP_ASR: flags_d[AMC_FLG_CARRY] = alu_carry;
			default: ;
		endcase
	end

	// restoring division step on the running remainder
	assign div_shift = {div_rem_q[14:0], div_quo_q[15]};
	assign div_trial = {1'b0, div_shift} - {1'b0, div_den_q};

	// operation sequencer: alu and multiply in one cycle, divide in sixteen steps with the result eighteen cycles after the request
	always_ff @(posedge sys_clk or negedge rst_n)
	begin
		if (!rst_n)
		begin
			state_q <= AMC_ST_IDLE;
			div_cnt_q <= 5'h00;
			div_rem_q <= 16'h0000;
			div_quo_q <= 16'h0000;
			div_den_q <= 16'h0000;
			div_neg_q <= 1'b0;
			div_rneg_q <= 1'b0;
			div_dst_q <= AMC_SRC_WREG;
		end
		else
		begin
			case (state_q)
				AMC_ST_IDLE:
				begin
					if (req_valid && (req.op == AMC_OP_DIVU || req.op == AMC_OP_DIVS))
					begin
						// signed divide runs on magnitudes, signs fixed at the end
						div_neg_q <= (req.op == AMC_OP_DIVS) && (req.opa[15] ^ req.opb[15]);
						div_rneg_q <= (req.op == AMC_OP_DIVS) && req.opa[15];
						div_quo_q <= (req.op == AMC_OP_DIVS && req.opa[15]) ? -req.opa : req.opa;
						div_den_q <= (req.op == AMC_OP_DIVS && req.opb[15]) ? -req.opb : req.opb;
						div_rem_q <= 16'h0000;
						div_cnt_q <= AMC_DIV_STEPS;
						div_dst_q <= req.dst;
						state_q <= AMC_ST_DIV;
					end
				end
				AMC_ST_DIV:
				begin
					if (div_trial[16])
					begin
						div_rem_q <= div_shift;
						div_quo_q <= {div_quo_q[14:0], 1'b0};
					end
					else
					begin
						div_rem_q <= div_trial[15:0];
						div_quo_q <= {div_quo_q[14:0], 1'b1};
					end
					div_cnt_q <= div_cnt_q - 5'h01;
					if (div_cnt_q == 5'h01)
						state_q <= AMC_ST_DIV_DONE;
				end
				AMC_ST_DIV_DONE: state_q <= AMC_ST_IDLE;
				default: state_q <= AMC_ST_IDLE;
			endcase
		end
	end

	// result registers and write steering toward register array or memory
	always_ff @(posedge sys_clk or negedge rst_n)
	begin
		if (!rst_n)
		begin
			rsp_valid_q <= 1'b0;
			rsp_q <= '0;
			res_lo_q <= 16'h0000;
			res_hi_q <= 16'h0000;
			rem_q <= 16'h0000;
			wreg_we_q <= 1'b0;
			dmem_we_q <= 1'b0;
		end
		else
		begin
			rsp_valid_q <= 1'b0;
			wreg_we_q <= 1'b0;
			dmem_we_q <= 1'b0;
			if (state_q == AMC_ST_IDLE && req_valid && req.op != AMC_OP_DIVU && req.op != AMC_OP_DIVS)
			begin
				rsp_valid_q <= 1'b1;
				rsp_q.dst <= req.dst;
				wreg_we_q <= (req.dst == AMC_SRC_WREG);
				dmem_we_q <= (req.dst == AMC_SRC_DMEM);
				if (req.op == AMC_OP_MUL)
				begin
					// byte mode yields 16 bits, word modes 32 bits
					rsp_q.low <= mul_product[15:0];
					rsp_q.high <= (req.mul_mode == AMC_MUL_BYTE) ? 16'h0000 : mul_product[31:16];
					rsp_q.flags <= alu_flag_word_q;
					res_lo_q <= mul_product[15:0];
					res_hi_q <= (req.mul_mode == AMC_MUL_BYTE) ? 16'h0000 : mul_product[31:16];
				end
				else
				begin
					rsp_q.low <= alu_res;
					rsp_q.high <= 16'h0000;
					rsp_q.flags <= flags_d;
					res_lo_q <= alu_res;
					res_hi_q <= 16'h0000;
				end
			end
			else if (state_q == AMC_ST_DIV_DONE)
			begin
				rsp_valid_q <= 1'b1;
				rsp_q.dst <= div_dst_q;
				wreg_we_q <= (div_dst_q == AMC_SRC_WREG);
				dmem_we_q <= (div_dst_q == AMC_SRC_DMEM);
				rsp_q.low <= div_neg_q ? -div_quo_q : div_quo_q;
				rsp_q.high <= div_rneg_q ? -div_rem_q : div_rem_q;
				rsp_q.flags <= alu_flag_word_q;
				res_lo_q <= div_neg_q ? -div_quo_q : div_quo_q;
				res_hi_q <= 16'h0000;
				rem_q <= div_rneg_q ? -div_rem_q : div_rem_q;
			end
		end
	end

	// status flag word: alu results win over a software write in the same cycle
	always_ff @(posedge sys_clk or negedge rst_n)
	begin
		if (!rst_n)
			alu_flag_word_q <= AMC_FLG_RESET;
		else if (state_q == AMC_ST_IDLE && req_valid && req.op != AMC_OP_MUL
			&& req.op != AMC_OP_DIVU && req.op != AMC_OP_DIVS)
			alu_flag_word_q <= flags_d;
		else if (reg_wr && reg_addr == AMC_OFF_FLAGS)
			alu_flag_word_q <= reg_wdata;
	end

	// priority status bit: hardware set wins over a software clear
	always_ff @(posedge sys_clk or negedge rst_n)
	begin
		if (!rst_n)
			priority_above_seven_status_q <= 1'b0;
		else if (cpu_priority > AMC_PRIO_LIMIT)
			priority_above_seven_status_q <= 1'b1;
		else if (reg_wr && reg_addr == AMC_OFF_CONTROL && !reg_wdata[AMC_CTL_PRIO_BIT])
			priority_above_seven_status_q <= 1'b0; // clearable
		else
			priority_above_seven_status_q <= 1'b0;
	end

	// program-space window bit, plain read/write
	always_ff @(posedge sys_clk or negedge rst_n)
	begin
		if (!rst_n)
			window_q <= AMC_CTL_RESET[AMC_CTL_WINDOW_BIT];
		else if (reg_wr && reg_addr == AMC_OFF_CONTROL)
			window_q <= reg_wdata[AMC_CTL_WINDOW_BIT];
	end

	// interrupt gate and busy flag, registered for clean outputs
	always_ff @(posedge sys_clk or negedge rst_n)
	begin
		if (!rst_n)
		begin
			irq_take_q <= 1'b0;
			busy_q <= 1'b0;
		end
		else
		begin
			irq_take_q <= user_irq_req && !(cpu_priority > AMC_PRIO_LIMIT);
			busy_q <= (state_q == AMC_ST_IDLE) ? (req_valid && (req.op == AMC_OP_DIVU || req.op == AMC_OP_DIVS))
				: (state_q == AMC_ST_DIV);
		end
	end

	// control view with unimplemented bits forced low
	always_comb
	begin
		ctl_view = 16'h0000;
		ctl_view[AMC_CTL_PRIO_BIT] = priority_above_seven_status_q;
		ctl_view[AMC_CTL_WINDOW_BIT] = window_q;
	end

	// register read port, data one cycle after the strobe; unmapped reads zero
	always_ff @(posedge sys_clk or negedge rst_n)
	begin
		if (!rst_n)
			rdata_q <= 16'h0000;
		else if (reg_rd)
		begin
			case (reg_addr)
				AMC_OFF_CONTROL: rdata_q <= ctl_view;
				AMC_OFF_FLAGS: rdata_q <= alu_flag_word_q;
				AMC_OFF_PRIORITY: rdata_q <= {12'h000, cpu_priority};
				AMC_OFF_RESULT: rdata_q <= res_lo_q;
				AMC_OFF_PROD_HI: rdata_q <= res_hi_q;
				AMC_OFF_REMAINDER: rdata_q <= rem_q;
				default: rdata_q <= 16'h0000;
			endcase
		end
		else
			rdata_q <= 16'h0000;
	end

	assign reg_rdata = rdata_q;
	assign rsp_valid = rsp_valid_q;
	assign rsp = rsp_q;
	assign busy = busy_q;
	assign wreg_we = wreg_we_q;
	assign dmem_we = dmem_we_q;
	assign user_irq_take = irq_take_q;
	assign program_space_window_enable = window_q;

endmodule : amc_core

// *** hw/amc_mul17.sv ***
// 17x17 signed array multiplier with per-operand sign extension
`timescale 1ns/1ps
module amc_mul17
	import amc_pkg::*;
(
	input wire logic [15:0] opa,
	input wire logic [15:0] opb,
	input wire amc_mul_mode_t mode,
	output logic [31:0] product
);

	logic a_signed;
	logic b_signed;
	logic [16:0] a_ext;
	logic [16:0] b_ext;
	logic signed [33:0] full;

	// pick operand signedness; literal and byte modes mask the b operand
	always_comb
	begin
		a_signed = 1'b0;
		b_signed = 1'b0;
		a_ext = {1'b0, opa};
		b_ext = {1'b0, opb};
		case (mode)
			AMC_MUL_SS:
			begin
				a_signed = 1'b1;
				b_signed = 1'b1;
			end
			AMC_MUL_SU_LIT:
			begin
				a_signed = 1'b1;
				b_ext = {12'h000, opb[4:0]};
			end
			AMC_MUL_UU_LIT: b_ext = {12'h000, opb[4:0]};
			AMC_MUL_US: b_signed = 1'b1;
			AMC_MUL_SU: a_signed = 1'b1;
			AMC_MUL_BYTE:
			begin
				a_ext = {9'h000, opa[7:0]};
				b_ext = {9'h000, opb[7:0]};
			end
			default: ;
		endcase
		if (a_signed)
			a_ext[16] = opa[15];
		if (b_signed)
			b_ext[16] = opb[15];
	end

	// the 17th bit lets one signed array cover every sign mix
	assign full = $signed(a_ext) * $signed(b_ext);
	assign product = full[31:0];

endmodule : amc_mul17

// *** hw/amc_pkg.sv ***
// package for the alu and multiplier core: offsets, layouts, encodings
package amc_pkg;

	localparam int AMC_WORD_W = 16;

	// register port offsets (word addresses on the plain register port)
	localparam logic [3:0] AMC_OFF_CONTROL = 4'h0;
	localparam logic [3:0] AMC_OFF_FLAGS = 4'h1;
	localparam logic [3:0] AMC_OFF_PRIORITY = 4'h2;
	localparam logic [3:0] AMC_OFF_RESULT = 4'h3;
	localparam logic [3:0] AMC_OFF_PROD_HI = 4'h4;
	localparam logic [3:0] AMC_OFF_REMAINDER = 4'h5;

	// control register field positions and reset value
	localparam int AMC_CTL_PRIO_BIT = 3;
	localparam int AMC_CTL_WINDOW_BIT = 2;
	localparam logic [15:0] AMC_CTL_RESET = 16'h0000;
	localparam logic [3:0] AMC_PRIO_LIMIT = 4'h7;

	// flag word field positions
	localparam int AMC_FLG_CARRY = 0;
	localparam int AMC_FLG_ZERO = 1;
	localparam int AMC_FLG_WRAP = 2;
	localparam int AMC_FLG_NEG = 3;
	localparam int AMC_FLG_NIBBLE = 8;
	localparam logic [15:0] AMC_FLG_RESET = 16'h0000;

	// divider step count, one quotient bit per cycle
	localparam logic [4:0] AMC_DIV_STEPS = 5'h10;

	typedef enum logic [3:0] {
		AMC_OP_ADD,
		AMC_OP_ADDC,
		AMC_OP_SUB,
		AMC_OP_SUBB,
		AMC_OP_AND,
		AMC_OP_OR,
		AMC_OP_XOR,
		AMC_OP_SHL,
		AMC_OP_SHR,
		AMC_OP_ASR,
		AMC_OP_MUL,
		AMC_OP_DIVU,
		AMC_OP_DIVS
	} amc_op_t;

	typedef enum logic [2:0] {
		AMC_MUL_SS,
		AMC_MUL_UU,
		AMC_MUL_SU_LIT,
		AMC_MUL_UU_LIT,
		AMC_MUL_US,
		AMC_MUL_SU,
		AMC_MUL_BYTE
	} amc_mul_mode_t;

	typedef enum logic {
		AMC_SRC_WREG,
		AMC_SRC_DMEM
	} amc_src_t;

	// one operation request from the decoder
	typedef struct packed {
		amc_op_t op;
		amc_mul_mode_t mul_mode;
		logic byte_mode;
		amc_src_t dst;
		logic [15:0] opa;
		logic [15:0] opb;
	} amc_req_t;

	// one result toward register array or data memory
	typedef struct packed {
		amc_src_t dst;
		logic [15:0] low;
		logic [15:0] high;
		logic [15:0] flags;
	} amc_rsp_t;

endpackage : amc_pkg

// *** sim/amc_core_props.sv ***
// concurrent checks on the alu and multiplier core ports
`timescale 1ns/1ps
module amc_core_props
	import amc_pkg::*;
(
	input wire logic sys_clk,
	input wire logic rst_n,
	input wire logic req_valid,
	input wire amc_req_t req,
	input wire logic [3:0] cpu_priority,
	input wire logic user_irq_req,
	input wire logic [3:0] reg_addr,
	input wire logic [15:0] reg_wdata,
	input wire logic reg_wr,
	input wire logic reg_rd,
	input wire logic [15:0] reg_rdata,
	input wire logic rsp_valid,
	input wire amc_rsp_t rsp,
	input wire logic busy,
	input wire logic wreg_we,
	input wire logic dmem_we,
	input wire logic user_irq_take,
	input wire logic program_space_window_enable
);
	default clocking cb @(posedge sys_clk);
	endclocking
	default disable iff (!rst_n);
	// request seen by an idle core; requests while busy are dropped
	wire take = req_valid && !busy;
	wire is_div = req.op inside {AMC_OP_DIVU, AMC_OP_DIVS};
	wire word_add = take && req.op == AMC_OP_ADD && !req.byte_mode;
	wire win_bit = reg_wdata[AMC_CTL_WINDOW_BIT];

	a_alu_answer: assert property (take && !is_div |=> rsp_valid)
		else $error("alu result missing");
	a_div_answer: assert property (take && is_div |=> busy [*8] ##10 rsp_valid)
		else $error("divide timing wrong");
	a_add_value: assert property (word_add |=> rsp.low == $past(req.opa) + $past(req.opb))
		else $error("add sum wrong");
	a_zero_neg: assert property (word_add |=> rsp.flags[AMC_FLG_ZERO] == (rsp.low == 16'h0000)
		&& rsp.flags[AMC_FLG_NEG] == rsp.low[15]) else $error("zero or negative flag wrong");
	a_byte_zext: assert property (take && req.byte_mode && !is_div && req.op != AMC_OP_MUL
		|=> rsp.low[15:8] == 8'h00) else $error("byte result not zero extended");
	a_mul_uu: assert property (take && req.op == AMC_OP_MUL && req.mul_mode == AMC_MUL_UU
		|=> {rsp.high, rsp.low} == $past(req.opa) * $past(req.opb)) else $error("product wrong");
	a_we_dst: assert property (wreg_we == (rsp_valid && rsp.dst == AMC_SRC_WREG)
		&& dmem_we == (rsp_valid && rsp.dst == AMC_SRC_DMEM)) else $error("write strobe wrong");
	a_irq_gate: assert property (1'b1 |=> user_irq_take ==
		($past(user_irq_req) && $past(cpu_priority) <= AMC_PRIO_LIMIT)) else $error("irq gate wrong");
	a_ctl_zero: assert property ($past(reg_rd) && $past(reg_addr) == AMC_OFF_CONTROL
		|-> (reg_rdata & 16'hfff3) == 16'h0000) else $error("unused control bits set");
	a_window_pin: assert property (reg_wr && reg_addr == AMC_OFF_CONTROL
		|=> program_space_window_enable == $past(win_bit)) else $error("window pin wrong");
endmodule : amc_core_props

bind amc_core amc_core_props u_props (.sys_clk, .rst_n, .req_valid, .req, .cpu_priority, .user_irq_req,
	.reg_addr, .reg_wdata, .reg_wr, .reg_rd, .reg_rdata, .rsp_valid, .rsp, .busy, .wreg_we, .dmem_we,
	.user_irq_take, .program_space_window_enable);

// *** sim/amc_sink_model.sv ***
// far-side model: register array and data memory write ports
`timescale 1ns/1ps
module amc_sink_model
	import amc_pkg::*;
(
	input wire logic sys_clk,
	input wire logic rst_n,
	input wire logic wreg_we,
	input wire logic dmem_we,
	input wire amc_rsp_t rsp,
	output logic [15:0] wreg_last,
	output logic [15:0] dmem_last
);
	// store each result only where its strobe points
	always_ff @(posedge sys_clk or negedge rst_n)
	begin
		if (!rst_n)
		begin
			wreg_last <= 16'h0000;
			dmem_last <= 16'h0000;
		end
		else
		begin
			if (wreg_we)
				wreg_last <= rsp.low;
			if (dmem_we)
				dmem_last <= rsp.low;
		end
	end
endmodule : amc_sink_model

// *** sim/tb_alu_multiplier_core.sv ***
// self-checking bench for the alu and multiplier core
`timescale 1ns/1ps
module tb_alu_multiplier_core
	import amc_pkg::*;
;
	logic sys_clk = 1'b0;
	logic rst_n = 1'b0;
	logic req_valid = 1'b0;
	amc_req_t req = '0;
	logic [3:0] cpu_priority = 4'h0;
	logic user_irq_req = 1'b0;
	logic [3:0] reg_addr = 4'h0;
	logic [15:0] reg_wdata = 16'h0000;
	logic reg_wr = 1'b0;
	logic reg_rd = 1'b0;
	logic [15:0] reg_rdata;
	logic rsp_valid;
	amc_rsp_t rsp;
	logic busy, wreg_we, dmem_we, user_irq_take, program_space_window_enable;
	logic [15:0] wreg_last, dmem_last;
	int fail_count = 0;
	int n_checks = 0;
	int cyc = 0;
	int lat;

	amc_core dut_u (.sys_clk, .rst_n, .req_valid, .req, .cpu_priority, .user_irq_req, .reg_addr, .reg_wdata,
		.reg_wr, .reg_rd, .reg_rdata, .rsp_valid, .rsp, .busy, .wreg_we, .dmem_we, .user_irq_take,
		.program_space_window_enable);
	amc_sink_model far_u (.sys_clk, .rst_n, .wreg_we, .dmem_we, .rsp, .wreg_last, .dmem_last);

	// 4 ns clock
	always #2 sys_clk = ~sys_clk;

	// hang guard, far above the roughly 150 cycles the run needs
	always @(posedge sys_clk)
	begin
		cyc++;
		if (cyc == 5000)
		begin
			fail_count++;
			stop_test();
		end
	end

	task automatic stop_test();
		if (fail_count == 0 && n_checks > 0)
			$display("All tests passed");
		else
			$display("Some tests failed");
		$finish;
	endtask : stop_test

	task automatic chk16(input string what, input logic [15:0] e, input logic [15:0] g);
		n_checks++;
		if (g !== e)
		begin
			fail_count++;
			$display("mismatch %s exp %h got %h", what, e, g);
		end
	endtask : chk16

	task automatic wr(input logic [3:0] a, input logic [15:0] d);
		@(posedge sys_clk);
		reg_wr <= 1'b1;
		reg_addr <= a;
		reg_wdata <= d;
		@(posedge sys_clk);
		reg_wr <= 1'b0;
	endtask : wr

	// read data stands only in the cycle after the strobe
	task automatic rdc(input string what, input logic [3:0] a, input logic [15:0] e);
		@(posedge sys_clk);
		reg_rd <= 1'b1;
		reg_addr <= a;
		@(posedge sys_clk);
		reg_rd <= 1'b0;
		#1 chk16(what, e, reg_rdata);
	endtask : rdc

	// rsp_valid stands one cycle only, so look just after every edge
	task automatic wait_rsp();
		#1;
		while (lat < 40 && rsp_valid !== 1'b1)
		begin
			@(posedge sys_clk);
			#1 lat++;
		end
		chk16("rsp_valid", 16'h0001, {15'h0000, rsp_valid});
	endtask : wait_rsp

	task automatic op(input amc_op_t o, input amc_mul_mode_t m, input logic bm, input amc_src_t d,
		input logic [15:0] a, input logic [15:0] b);
		@(posedge sys_clk);
		req_valid <= 1'b1;
		req <= '{op: o, mul_mode: m, byte_mode: bm, dst: d, opa: a, opb: b};
		@(posedge sys_clk);
		req_valid <= 1'b0;
		lat = 1;
		wait_rsp();
	endtask : op

	task automatic ac(input amc_op_t o, input logic bm, input logic [15:0] a, input logic [15:0] b,
		input logic [15:0] e, input logic [15:0] fe, input logic [15:0] fm);
		op(o, AMC_MUL_SS, bm, AMC_SRC_WREG, a, b);
		chk16("alu low", e, rsp.low);
		chk16("alu flags", fe, rsp.flags & fm);
		chk16("alu latency", 16'h0001, 16'(lat));
	endtask : ac

	task automatic mc(input amc_mul_mode_t m, input logic bm, input logic [15:0] a, input logic [15:0] b,
		input logic [31:0] e);
		op(AMC_OP_MUL, m, bm, AMC_SRC_WREG, a, b);
		chk16("product low", e[15:0], rsp.low);
		chk16("product high", e[31:16], rsp.high);
		chk16("mul latency", 16'h0001, 16'(lat));
	endtask : mc

	task automatic t_regs();
		rdc("ctl reset", AMC_OFF_CONTROL, AMC_CTL_RESET);
		rdc("flag reset", AMC_OFF_FLAGS, AMC_FLG_RESET);
		wr(AMC_OFF_CONTROL, 16'hffff);
		rdc("ctl ones", AMC_OFF_CONTROL, 16'h0004);
		chk16("window pin", 16'h0001, {15'h0000, program_space_window_enable});
		wr(AMC_OFF_CONTROL, 16'h0000);
		rdc("ctl clear", AMC_OFF_CONTROL, 16'h0000);
		rdc("unmapped", 4'hf, 16'h0000);
	endtask : t_regs

	// a software clear cannot beat a live priority above seven
	task automatic t_prio();
		@(posedge sys_clk);
		cpu_priority <= 4'h8;
		user_irq_req <= 1'b1;
		repeat (3) @(posedge sys_clk);
		#1 chk16("irq blocked", 16'h0000, {15'h0000, user_irq_take});
		rdc("ctl prio", AMC_OFF_CONTROL, 16'h0008);
		wr(AMC_OFF_CONTROL, 16'h0000);
		rdc("ctl set wins", AMC_OFF_CONTROL, 16'h0008);
		@(posedge sys_clk);
		cpu_priority <= 4'h7;
		repeat (3) @(posedge sys_clk);
		#1 chk16("irq passed", 16'h0001, {15'h0000, user_irq_take});
		rdc("ctl prio low", AMC_OFF_CONTROL, 16'h0000);
		@(posedge sys_clk);
		user_irq_req <= 1'b0;
	endtask : t_prio

	// flags: carry 0, zero 1, wrap 2, negative 3, nibble 8
	task automatic t_alu();
		ac(AMC_OP_ADD, 1'b0, 16'hffff, 16'h0001, 16'h0000, 16'h0103, 16'h010f);
		ac(AMC_OP_ADDC, 1'b0, 16'h0001, 16'h0001, 16'h0003, 16'h0000, 16'h010f);
		ac(AMC_OP_ADD, 1'b0, 16'h7fff, 16'h0001, 16'h8000, 16'h010c, 16'h010f);
		ac(AMC_OP_ADD, 1'b1, 16'h0080, 16'h0080, 16'h0000, 16'h0007, 16'h010f);
		ac(AMC_OP_SUB, 1'b0, 16'h0005, 16'h0007, 16'hfffe, 16'h0008, 16'h010f);
		ac(AMC_OP_SUB, 1'b0, 16'h0007, 16'h0005, 16'h0002, 16'h0101, 16'h010f);
		ac(AMC_OP_SUBB, 1'b0, 16'h0005, 16'h0002, 16'h0003, 16'h0101, 16'h010f);
		ac(AMC_OP_SUB, 1'b0, 16'h8000, 16'h0001, 16'h7fff, 16'h0005, 16'h010f);
		ac(AMC_OP_AND, 1'b0, 16'hf0f0, 16'h0f0f, 16'h0000, 16'h0002, 16'h000a);
		ac(AMC_OP_OR, 1'b0, 16'h8000, 16'h0001, 16'h8001, 16'h0008, 16'h000a);
		ac(AMC_OP_XOR, 1'b0, 16'h1234, 16'h1234, 16'h0000, 16'h0002, 16'h000a);
		ac(AMC_OP_SHL, 1'b0, 16'h0001, 16'h0004, 16'h0002, 16'h0000, 16'h000a);
		ac(AMC_OP_SHR, 1'b0, 16'h8000, 16'h0004, 16'h4000, 16'h0000, 16'h000a);
		ac(AMC_OP_ASR, 1'b0, 16'h8000, 16'h0004, 16'hc000, 16'h0008, 16'h000a);
	endtask : t_alu

	task automatic t_mul();
		mc(AMC_MUL_SS, 1'b0, 16'hfffe, 16'h0003, 32'hfffffffa);
		mc(AMC_MUL_UU, 1'b0, 16'hffff, 16'hffff, 32'hfffe0001);
		mc(AMC_MUL_US, 1'b0, 16'hffff, 16'hffff, 32'hffff0001);
		mc(AMC_MUL_SU, 1'b0, 16'hffff, 16'hffff, 32'hffff0001);
		mc(AMC_MUL_SU_LIT, 1'b0, 16'hfffe, 16'h0005, 32'hfffffff6);
		mc(AMC_MUL_UU_LIT, 1'b0, 16'h1000, 16'h001f, 32'h0001f000);
		mc(AMC_MUL_BYTE, 1'b1, 16'h00ff, 16'h00ff, 32'h0000fe01);
	endtask : t_mul

	// second request held during the divide must be dropped
	task automatic t_div();
		@(posedge sys_clk);
		req_valid <= 1'b1;
		req <= '{op: AMC_OP_DIVU, mul_mode: AMC_MUL_SS, byte_mode: 1'b0, dst: AMC_SRC_WREG, opa: 16'h0064, opb: 16'h0007};
		@(posedge sys_clk);
		req.op <= AMC_OP_ADD;
		@(posedge sys_clk);
		req_valid <= 1'b0;
		lat = 2;
		wait_rsp();
		chk16("div latency", 16'h0012, 16'(lat));
		chk16("quotient", 16'h000e, rsp.low);
		chk16("remainder", 16'h0002, rsp.high);
		op(AMC_OP_DIVS, AMC_MUL_SS, 1'b0, AMC_SRC_WREG, 16'hff9c, 16'h0007);
		chk16("signed quotient", 16'hfff2, rsp.low);
		rdc("remainder reg", AMC_OFF_REMAINDER, 16'hfffe);
		op(AMC_OP_DIVU, AMC_MUL_SS, 1'b0, AMC_SRC_WREG, 16'h0005, 16'h0000);
		chk16("div by zero", 16'hffff, rsp.low);
	endtask : t_div

	task automatic t_dst();
		op(AMC_OP_ADD, AMC_MUL_SS, 1'b0, AMC_SRC_DMEM, 16'h0001, 16'h0002);
		op(AMC_OP_ADD, AMC_MUL_SS, 1'b0, AMC_SRC_WREG, 16'h0004, 16'h0005);
		@(posedge sys_clk);
		#1 chk16("memory copy", 16'h0003, dmem_last);
		chk16("register copy", 16'h0009, wreg_last);
		rdc("result reg", AMC_OFF_RESULT, 16'h0009);
	endtask : t_dst

	// reset, then each scenario in turn
	initial
	begin
		repeat (10) @(posedge sys_clk);
		rst_n <= 1'b1;
		t_regs();
		t_prio();
		t_alu();
		t_mul();
		t_div();
		t_dst();
		stop_test();
	end
endmodule : tb_alu_multiplier_core
